// ---- mct_pkg.sv ----
// Shared constants and helpers for the motor current transform datapath
package mct_pkg;
    localparam logic [3:0] TASK_PHASE = 4'h3;
    localparam logic [3:0] TASK_COORD = 4'h4;
    localparam logic [3:0] TASK_ATAN = 4'hc;
    localparam logic [3:0] TASK_SQRT = 4'hd;
    // 1/sqrt(3) in Q1.31
    localparam logic signed [63:0] INV_SQRT3 = 64'sh0000_0000_49e6_9d16;
    localparam int FRAC_I = 31;
    localparam int FRAC_A = 15;
    localparam logic [31:0] Q31_MAX = 32'h7fff_ffff;
    localparam logic [31:0] Q31_MIN = 32'h8000_0000;
    localparam logic signed [63:0] Q31_MAX_W = 64'sh0000_0000_7fff_ffff;
    localparam logic signed [63:0] Q31_MIN_W = 64'shffff_ffff_8000_0000;
    localparam logic signed [31:0] ANG_MAX = 32'sh0000_2000;
    localparam logic signed [31:0] ANG_MIN = 32'shffff_e000;
    localparam logic signed [34:0] ONE_Q31 = 35'sh0_7fff_ffff;
    localparam logic [31:0] SQRT_IN_MAX = 32'h0002_0000;
    localparam logic [31:0] SQRT_OUT_MAX = 32'h0001_0000;
    localparam logic [3:0] CORDIC_LAST = 4'hd;
    localparam logic [4:0] SQRT_LAST = 5'h17;
    localparam logic [1:0] SLOT_CUR1 = 2'h0;
    localparam logic [1:0] SLOT_CUR2 = 2'h1;
    localparam logic [1:0] SLOT_CUR3 = 2'h2;
    localparam logic [1:0] SLOT_VDC = 2'h3;
    localparam int IDMODE_SHUNT1_BIT = 1;

    // Angle step atan(2^-i), 45 deg = 0x2000
    function automatic logic signed [15:0] mct_atan_step(input logic [3:0] i);
        logic signed [15:0] r;
        r = 16'sh0000;
        unique case (i)
            4'h0: r = 16'sh2000;
            4'h1: r = 16'sh12e4;
            4'h2: r = 16'sh09fb;
            4'h3: r = 16'sh0511;
            4'h4: r = 16'sh028b;
            4'h5: r = 16'sh0146;
            4'h6: r = 16'sh00a3;
            4'h7: r = 16'sh0051;
            4'h8: r = 16'sh0029;
            4'h9: r = 16'sh0014;
            4'ha: r = 16'sh000a;
            4'hb: r = 16'sh0005;
            4'hc: r = 16'sh0003;
            default: r = 16'sh0001;
        endcase
        return r;
    endfunction : mct_atan_step

    function automatic logic [31:0] mct_sat_q31(input logic signed [63:0] v);
        if (v > Q31_MAX_W) begin
            return Q31_MAX;
        end else if (v < Q31_MIN_W) begin
            return Q31_MIN;
        end
        return v[31:0];
    endfunction : mct_sat_q31
endpackage : mct_pkg

// ---- mct_atan.sv ----
// Iterative CORDIC arctangent of num/den, den not negative
`timescale 1ns/1ps
`default_nettype none
module mct_atan
    import mct_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic signed [34:0] num,
    input wire logic signed [34:0] den,
    output logic done,
    output logic [31:0] result
);
    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
        logic signed [34:0] x;
        logic signed [34:0] y;
        logic signed [15:0] z;
        logic sat_pos;
        logic sat_neg;
        logic done;
        logic [31:0] res;
    } mct_atan_t;

    mct_atan_t s_reg, s_next;
    logic signed [31:0] z_w;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        z_w = 32'(s_reg.z);
        if (start && !s_reg.busy) begin
            s_next.busy = 1'b1;
            s_next.cnt = 4'h0;
            s_next.x = den;
            s_next.y = num;
            s_next.z = 16'sh0000;
            // Unit ratio taken exactly; the iteration lands a code short of 45 degrees
            s_next.sat_pos = (num >= den);
            s_next.sat_neg = (-num >= den);
        end else if (s_reg.busy) begin
            if (s_reg.y < 0) begin
                s_next.x = s_reg.x - (s_reg.y >>> s_reg.cnt);
                s_next.y = s_reg.y + (s_reg.x >>> s_reg.cnt);
                s_next.z = s_reg.z - mct_atan_step(s_reg.cnt);
            end else begin
                s_next.x = s_reg.x + (s_reg.y >>> s_reg.cnt);
                s_next.y = s_reg.y - (s_reg.x >>> s_reg.cnt);
                s_next.z = s_reg.z + mct_atan_step(s_reg.cnt);
            end
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == CORDIC_LAST) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                // Ratios past one clip to the 45 degree codes
                z_w = 32'(s_next.z);
                if (s_reg.sat_pos) begin
                    s_next.res = ANG_MAX;
                end else if (s_reg.sat_neg) begin
                    s_next.res = ANG_MIN;
                end else begin
                    s_next.res = (z_w > ANG_MAX) ? ANG_MAX : (z_w < ANG_MIN) ? ANG_MIN : z_w;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
    assign result = s_reg.res;
endmodule : mct_atan
`default_nettype wire

// ---- mct_sqrt.sv ----
// Bit-serial square root, unsigned Q17.15 in and out
`timescale 1ns/1ps
`default_nettype none
module mct_sqrt
    import mct_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [31:0] value,
    output logic done,
    output logic [31:0] result
);
    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [47:0] rad;
        logic [25:0] rem;
        logic [23:0] root;
        logic done;
        logic [31:0] res;
    } mct_sqrt_t;

    mct_sqrt_t s_reg, s_next;
    logic [25:0] rem_w;
    logic [25:0] trial;
    logic [31:0] clip;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        rem_w = {s_reg.rem[23:0], s_reg.rad[47:46]};
        trial = {s_reg.root, 2'b01};
        // Inputs above 4.0 are clipped so the root stays within 2.0
        clip = (value > SQRT_IN_MAX) ? SQRT_IN_MAX : value;
        if (start && !s_reg.busy) begin
            s_next.busy = 1'b1;
            s_next.cnt = 5'h00;
            s_next.rad = {clip, 16'h0000} >> 1;
            s_next.rem = 26'h000_0000;
            s_next.root = 24'h00_0000;
        end else if (s_reg.busy) begin
            s_next.rad = {s_reg.rad[45:0], 2'b00};
            if (rem_w >= trial) begin
                s_next.rem = rem_w - trial;
                s_next.root = {s_reg.root[22:0], 1'b1};
            end else begin
                s_next.rem = rem_w;
                s_next.root = {s_reg.root[22:0], 1'b0};
            end
            s_next.cnt = s_reg.cnt + 5'h01;
            if (s_reg.cnt == SQRT_LAST) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.res = {8'h00, s_next.root};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done = s_reg.done;
    assign result = s_reg.res;
endmodule : mct_sqrt
`default_nettype wire

// ---- mct_core.sv ----
// Motor current transform: phase, coordinate, arctangent and root tasks
//
// How it works
// - Task 3 copies a-phase current to alpha.
// - Beta is (b minus c) times one over root3.
// - Phase and alpha/beta values are signed Q1.31.
// - Task 4: d equals cos*alpha plus sin*beta.
// - q equals cos*beta minus sin*alpha, Q1.31.
// - Sine and cosine inputs are signed Q1.15.
// - Vector phase runs only when enable bit set.
// - Vector phase is atan(d/q) into scratch register.
// - Phase result clipped to 0xFFFFE000..0x00002000.
// - Task 12 replaces scratch with its arctangent.
// - Atan input Q1.31, 45 degrees maps to limits.
// - Task 13 replaces scratch with its root.
// - Root input and output unsigned, 15 fraction bits.
// - Slots 0-2 currents, 3 supply; slot 2 conditional.
`timescale 1ns/1ps
`default_nettype none
module mct_core
    import mct_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic task_start,
    input wire logic [3:0] task_num,
    input wire logic [31:0] phase_a_current_tmp,
    input wire logic [31:0] phase_b_current_tmp,
    input wire logic [31:0] phase_c_current_tmp,
    input wire logic [15:0] angle_sine_value,
    input wire logic [15:0] angle_cosine_value,
    input wire logic vector_phase_calc_enable,
    input wire logic phase_conv_disable,
    input wire logic [1:0] current_detect_mode,
    input wire logic pwm_shift2_mode,
    input wire logic scratch_wr,
    input wire logic [31:0] scratch_wdata,
    output logic task_busy,
    output logic task_done,
    output logic [31:0] alpha_current_tmp,
    output logic [31:0] beta_current_tmp,
    output logic [31:0] direct_axis_current,
    output logic [31:0] quadrature_axis_current,
    output logic [31:0] scratch_result_tmp,
    output logic current3_slot_used
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ATAN_GO = 5'b00010,
        ST_ATAN_WAIT = 5'b00100,
        ST_SQRT_GO = 5'b01000,
        ST_SQRT_WAIT = 5'b10000
    } mct_state_t;

    typedef struct packed {
        mct_state_t st;
        logic done;
        logic [31:0] alpha;
        logic [31:0] beta;
        logic [31:0] id;
        logic [31:0] iq;
        logic [31:0] scratch;
        logic signed [34:0] num;
        logic signed [34:0] den;
        logic cur3;
    } mct_core_t;

    mct_core_t s_reg, s_next;

    logic signed [63:0] pb;
    logic signed [63:0] pc;
    logic signed [127:0] beta_full;
    logic signed [63:0] sin_w;
    logic signed [63:0] cos_w;
    logic signed [63:0] al_w;
    logic signed [63:0] be_w;
    logic signed [63:0] id_full;
    logic signed [63:0] iq_full;
    logic [31:0] id_sat;
    logic [31:0] iq_sat;
    logic atan_done;
    logic sqrt_done;
    logic [31:0] atan_res;
    logic [31:0] sqrt_res;
    logic go;

    // Full-width products so nothing is lost before the final shift
    always_comb begin
        pb = 64'(signed'(phase_b_current_tmp));
        pc = 64'(signed'(phase_c_current_tmp));
        beta_full = (128'(pb - pc) * 128'(INV_SQRT3)) >>> FRAC_I;
        sin_w = 64'(signed'(angle_sine_value));
        cos_w = 64'(signed'(angle_cosine_value));
        al_w = 64'(signed'(s_reg.alpha));
        be_w = 64'(signed'(s_reg.beta));
        id_full = (cos_w * al_w + sin_w * be_w) >>> FRAC_A;
        iq_full = (cos_w * be_w - sin_w * al_w) >>> FRAC_A;
        id_sat = mct_sat_q31(id_full);
        iq_sat = mct_sat_q31(iq_full);
    end

    assign go = task_start && (s_reg.st == ST_IDLE);

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        // Slot 2 carries a current in three-shunt modes, else only under shift 2
        s_next.cur3 = !current_detect_mode[IDMODE_SHUNT1_BIT] || pwm_shift2_mode;
        if (scratch_wr && s_reg.st == ST_IDLE) begin
            s_next.scratch = scratch_wdata;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (task_start) begin
                    unique case (task_num)
                        TASK_PHASE: begin
                            if (!phase_conv_disable) begin
                                s_next.alpha = phase_a_current_tmp;
                                s_next.beta = mct_sat_q31(beta_full[63:0]);
                            end
                            s_next.done = 1'b1;
                        end
                        TASK_COORD: begin
                            s_next.id = id_sat;
                            s_next.iq = iq_sat;
                            // Negate both when q is negative so den is never negative
                            if (signed'(iq_sat) < 0) begin
                                s_next.num = -35'(signed'(id_sat));
                                s_next.den = -35'(signed'(iq_sat));
                            end else begin
                                s_next.num = 35'(signed'(id_sat));
                                s_next.den = 35'(signed'(iq_sat));
                            end
                            if (vector_phase_calc_enable) begin
                                s_next.st = ST_ATAN_GO;
                            end else begin
                                s_next.done = 1'b1;
                            end
                        end
                        TASK_ATAN: begin
                            s_next.num = 35'(signed'(s_reg.scratch));
                            s_next.den = ONE_Q31;
                            s_next.st = ST_ATAN_GO;
                        end
                        TASK_SQRT: begin
                            s_next.st = ST_SQRT_GO;
                        end
                        default: begin
                            s_next.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_ATAN_GO: begin
                s_next.st = ST_ATAN_WAIT;
            end
            ST_ATAN_WAIT: begin
                if (atan_done) begin
                    s_next.scratch = atan_res;
                    s_next.done = 1'b1;
                    s_next.st = ST_IDLE;
                end
            end
            ST_SQRT_GO: begin
                s_next.st = ST_SQRT_WAIT;
            end
            ST_SQRT_WAIT: begin
                if (sqrt_done) begin
                    s_next.scratch = sqrt_res;
                    s_next.done = 1'b1;
                    s_next.st = ST_IDLE;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    mct_atan u_atan (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(s_reg.st == ST_ATAN_GO),
        .num(s_reg.num),
        .den(s_reg.den),
        .done(atan_done),
        .result(atan_res)
    );

    mct_sqrt u_sqrt (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(s_reg.st == ST_SQRT_GO),
        .value(s_reg.scratch),
        .done(sqrt_done),
        .result(sqrt_res)
    );

    assign task_busy = (s_reg.st != ST_IDLE);
    assign task_done = s_reg.done;
    assign alpha_current_tmp = s_reg.alpha;
    assign beta_current_tmp = s_reg.beta;
    assign direct_axis_current = s_reg.id;
    assign quadrature_axis_current = s_reg.iq;
    assign scratch_result_tmp = s_reg.scratch;
    assign current3_slot_used = s_reg.cur3;

    // Checks
    property p_alpha_copy;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_PHASE && !phase_conv_disable
            |=> alpha_current_tmp == $past(phase_a_current_tmp) && task_done;
    endproperty
    a_alpha_copy: assert property (p_alpha_copy) else $error("alpha not copied");

    property p_beta_sign;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_PHASE && !phase_conv_disable
            && signed'(phase_b_current_tmp) > signed'(phase_c_current_tmp)
            |=> !beta_current_tmp[31];
    endproperty
    a_beta_sign: assert property (p_beta_sign) else $error("beta sign wrong");

    property p_d_axis;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_COORD && angle_sine_value == 16'h0000
            && angle_cosine_value == 16'h4000 |=> direct_axis_current == 32'($signed(al_w) >>> 1);
    endproperty
    a_d_axis: assert property (p_d_axis) else $error("d axis wrong");

    property p_q_axis;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_COORD && angle_cosine_value == 16'h0000
            && angle_sine_value == 16'h4000 |=> quadrature_axis_current == 32'((-al_w) >>> 1);
    endproperty
    a_q_axis: assert property (p_q_axis) else $error("q axis wrong");

    property p_skip_phase;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_COORD && !vector_phase_calc_enable
            |=> task_done && !task_busy && $stable(scratch_result_tmp);
    endproperty
    a_skip_phase: assert property (p_skip_phase) else $error("phase not skipped");

    property p_phase_run;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_COORD && vector_phase_calc_enable
            |=> task_busy ##[15:18] task_done;
    endproperty
    a_phase_run: assert property (p_phase_run) else $error("phase late");

    property p_atan_range;
        @(posedge mclk) disable iff (sys_rst)
        s_reg.st == ST_ATAN_WAIT && atan_done
            |=> signed'(scratch_result_tmp) <= ANG_MAX && signed'(scratch_result_tmp) >= ANG_MIN;
    endproperty
    a_atan_range: assert property (p_atan_range) else $error("atan out of range");

    property p_atan_task;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_ATAN && scratch_result_tmp == Q31_MAX
            |=> ##[15:18] task_done && scratch_result_tmp == ANG_MAX;
    endproperty
    a_atan_task: assert property (p_atan_task) else $error("atan of one wrong");

    property p_sqrt_task;
        @(posedge mclk) disable iff (sys_rst)
        go && task_num == TASK_SQRT |=> ##[26:28] task_done && scratch_result_tmp <= SQRT_OUT_MAX;
    endproperty
    a_sqrt_task: assert property (p_sqrt_task) else $error("sqrt wrong");

    property p_slot3;
        @(posedge mclk) disable iff (sys_rst)
        !current_detect_mode[IDMODE_SHUNT1_BIT] |=> current3_slot_used;
    endproperty
    a_slot3: assert property (p_slot3) else $error("slot 2 unused");

    c_phase: cover property (@(posedge mclk) disable iff (sys_rst) go && task_num == TASK_PHASE);
    c_coord: cover property (@(posedge mclk) disable iff (sys_rst) s_reg.st == ST_ATAN_WAIT && atan_done);
    c_sqrt: cover property (@(posedge mclk) disable iff (sys_rst) s_reg.st == ST_SQRT_WAIT && sqrt_done);
endmodule : mct_core
`default_nettype wire

// ---- motor_current_transform_tb.sv ----
// Self-checking bench for the motor current transform datapath
`timescale 1ns/1ps
`default_nettype none
module motor_current_transform_tb;
    import mct_pkg::*;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [15:0] s;
        logic [15:0] co;
    } mct_row_t;
    logic mclk = 1'b0;
    logic sys_rst, task_start, vector_phase_calc_enable, phase_conv_disable, pwm_shift2_mode, scratch_wr;
    logic [3:0] task_num;
    logic [31:0] phase_a_current_tmp, phase_b_current_tmp, phase_c_current_tmp, scratch_wdata;
    logic [15:0] angle_sine_value, angle_cosine_value;
    logic [1:0] current_detect_mode;
    logic task_busy, task_done, current3_slot_used;
    logic [31:0] alpha_current_tmp, beta_current_tmp, direct_axis_current, quadrature_axis_current;
    logic [31:0] scratch_result_tmp;
    int n_mismatch = 0;
    int n_tests = 0;
    mct_row_t rows [4] = '{'{32'h4000_0000, 32'h2000_0000, 32'he000_0000, 16'h0000, 16'h7fff},
        '{32'h8000_0000, 32'h7fff_ffff, 32'h8000_0000, 16'h8000, 16'h8000},
        '{32'h1234_5678, 32'hc000_0000, 32'h3000_0000, 16'h5a82, 16'ha57e},
        '{32'h2345_6789, 32'h0000_0000, 32'h0000_0000, 16'h4000, 16'h0000}};
    logic [31:0] at_in [5] = '{32'h4000_0000, 32'h8000_0000, 32'h0000_0000, 32'hc000_0000, 32'h7fff_ffff};
    logic [31:0] at_ex [5] = '{32'h0000_12e4, 32'hffff_e000, 32'h0000_0000, 32'hffff_ed1c, 32'h0000_2000};
    logic [31:0] sq_in [6] = '{32'h0002_0000, 32'h0000_8000, 32'h0000_2000, 32'h0001_0000, 32'h0, 32'h0003_0000};
    logic [31:0] sq_ex [6] = '{32'h0001_0000, 32'h0000_8000, 32'h0000_4000, 32'h0000_b504, 32'h0, 32'h0001_0000};

    always #5 mclk = ~mclk;

    mct_core u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .task_start(task_start), .task_num(task_num),
        .phase_a_current_tmp(phase_a_current_tmp), .phase_b_current_tmp(phase_b_current_tmp),
        .phase_c_current_tmp(phase_c_current_tmp), .angle_sine_value(angle_sine_value),
        .angle_cosine_value(angle_cosine_value), .vector_phase_calc_enable(vector_phase_calc_enable),
        .phase_conv_disable(phase_conv_disable), .current_detect_mode(current_detect_mode),
        .pwm_shift2_mode(pwm_shift2_mode), .scratch_wr(scratch_wr), .scratch_wdata(scratch_wdata),
        .task_busy(task_busy), .task_done(task_done), .alpha_current_tmp(alpha_current_tmp),
        .beta_current_tmp(beta_current_tmp), .direct_axis_current(direct_axis_current),
        .quadrature_axis_current(quadrature_axis_current), .scratch_result_tmp(scratch_result_tmp),
        .current3_slot_used(current3_slot_used)
    );

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // Tolerance absorbs rounding order of the fixed-point products
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        logic signed [32:0] d;
        n_tests++;
        d = $signed({got[31], got}) - $signed({exp[31], exp});
        if (^got === 1'bx || d > tol || d < -tol) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] sat(input logic signed [63:0] v);
        if (v > Q31_MAX_W) return 32'h7fff_ffff;
        if (v < Q31_MIN_W) return 32'h8000_0000;
        return v[31:0];
    endfunction : sat

    function automatic logic [31:0] ex_beta(input logic signed [31:0] b, input logic signed [31:0] c);
        logic signed [63:0] dl;
        dl = b;
        dl = dl - c;
        return sat((dl * INV_SQRT3) >>> 31);
    endfunction : ex_beta

    function automatic logic [31:0] ex_mac(input logic signed [15:0] k1, input logic signed [31:0] x1,
                                           input logic neg, input logic signed [15:0] k2,
                                           input logic signed [31:0] x2);
        logic signed [63:0] p;
        logic signed [63:0] r;
        p = k1;
        p = p * x1;
        if (neg) p = -p;
        r = k2;
        r = r * x2;
        return sat((p + r) >>> 15);
    endfunction : ex_mac

    task automatic run(input logic [3:0] num, input int lat);
        int n;
        @(posedge mclk);
        task_start <= 1'b1;
        task_num <= num;
        @(posedge mclk);
        task_start <= 1'b0;
        #1;
        n = 1;
        while (task_done !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(n, lat, 0);
    endtask : run

    task automatic wscr(input logic [31:0] v);
        @(posedge mclk);
        scratch_wr <= 1'b1;
        scratch_wdata <= v;
        @(posedge mclk);
        scratch_wr <= 1'b0;
    endtask : wscr

    task automatic set_in(input mct_row_t r);
        @(posedge mclk);
        phase_a_current_tmp <= r.a;
        phase_b_current_tmp <= r.b;
        phase_c_current_tmp <= r.c;
        angle_sine_value <= r.s;
        angle_cosine_value <= r.co;
    endtask : set_in

    initial begin
        #100_000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        {task_start, vector_phase_calc_enable, phase_conv_disable, pwm_shift2_mode, scratch_wr} = '0;
        {task_num, current_detect_mode, scratch_wdata} = '0;
        {phase_a_current_tmp, phase_b_current_tmp, phase_c_current_tmp} = '0;
        {angle_sine_value, angle_cosine_value} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk({29'h0, task_busy, task_done, current3_slot_used}, 32'h0, 0);
        chk(alpha_current_tmp, 32'h0, 0);
        chk(scratch_result_tmp, 32'h0, 0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            @(posedge mclk);
            current_detect_mode <= m[1:0];
            pwm_shift2_mode <= m[2];
            @(posedge mclk);
            #1;
            chk(current3_slot_used, {31'h0, ~m[1] | m[2]}, 0);
        end
        for (int i = 0; i < 4; i++) begin
            set_in(rows[i]);
            run(TASK_PHASE, 1);
            chk(alpha_current_tmp, rows[i].a, 0);
            chk(beta_current_tmp, ex_beta(rows[i].b, rows[i].c), 1);
            run(TASK_COORD, 1);
            chk(direct_axis_current, ex_mac(rows[i].co, rows[i].a, 1'b0, rows[i].s,
                ex_beta(rows[i].b, rows[i].c)), 3);
            chk(quadrature_axis_current, ex_mac(rows[i].s, rows[i].a, 1'b1, rows[i].co,
                ex_beta(rows[i].b, rows[i].c)), 3);
        end
        // Disabled transform still answers but leaves alpha alone
        phase_conv_disable <= 1'b1;
        set_in('{32'h1111_1111, 32'h0, 32'h0, 16'h0, 16'h4000});
        run(TASK_PHASE, 1);
        chk(alpha_current_tmp, rows[3].a, 0);
        phase_conv_disable <= 1'b0;
        wscr(32'h1234_5678);
        run(TASK_COORD, 1);
        chk(scratch_result_tmp, 32'h1234_5678, 0);
        vector_phase_calc_enable <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            set_in('{32'h4000_0000, 32'h0, 32'h0, k ? 16'h4000 : 16'hc000, 16'h4000});
            run(TASK_PHASE, 1);
            run(TASK_COORD, 17);
            chk(scratch_result_tmp, k ? 32'hffff_e000 : 32'h0000_2000, 8);
        end
        vector_phase_calc_enable <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wscr(at_in[i]);
            run(TASK_ATAN, 17);
            chk(scratch_result_tmp, at_ex[i], 8);
        end
        for (int i = 0; i < 6; i++) begin
            wscr(sq_in[i]);
            run(TASK_SQRT, 27);
            chk(scratch_result_tmp, sq_ex[i], 0);
        end
        // Requests while busy must be dropped
        wscr(32'h4000_0000);
        @(posedge mclk);
        task_start <= 1'b1;
        task_num <= TASK_ATAN;
        @(posedge mclk);
        task_num <= TASK_PHASE;
        phase_a_current_tmp <= 32'h5555_5555;
        @(posedge mclk);
        task_start <= 1'b0;
        scratch_wr <= 1'b1;
        scratch_wdata <= 32'h7777_7777;
        #1;
        chk({31'h0, task_busy}, 32'h1, 0);
        @(posedge mclk);
        scratch_wr <= 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk(alpha_current_tmp, 32'h4000_0000, 0);
        chk(scratch_result_tmp, 32'h0000_12e4, 8);
        run(4'h5, 40);
        // Reset in the middle of a root aborts it
        wscr(32'h0001_0000);
        @(posedge mclk);
        task_start <= 1'b1;
        task_num <= TASK_SQRT;
        @(posedge mclk);
        task_start <= 1'b0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        #1;
        chk({30'h0, task_busy, task_done}, 32'h0, 0);
        chk(scratch_result_tmp, 32'h0, 0);
        chk(direct_axis_current, 32'h0, 0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (30) @(posedge mclk);
        #1;
        chk(scratch_result_tmp, 32'h0, 0);
        complete_run();
    end
endmodule : motor_current_transform_tb
`default_nettype wire
